// ===== include/cursor_pkg.sv
// Constants, types and field layout of the hardware cursor generator
// Behaviour
// - Output modes: one bit per clock, or four or five consecutive pixels per clock.
// - Write with codes 00..11: pointer low, pointer high, cursor RAM, control register.
// - Read with the same four codes returns the same four targets.
// - Pointer bits 8..0 address cursor RAM bytes 0 to 0x1FF directly.
// - Low four pointer bits pick the control register; upper bits are ignored.
// - RAM data bit 7 is the left-most of its eight pixels.
// - Each set bitmap bit drives a one in its pixel's cycle and lane.
// - Cursor x,y place bitmap column 31 and row 31; y grows downward.
// - Pixel count restarts at the first clock edge after horizontal sync falls.
// - Line count restarts at hsync fall two or more clocks after vsync falls.
// - Cross hair intersects at cursor x,y, centred for thicker lines.
// - Cross hair pixels drive a one in their cycle and lane.
// - Cross hair appears only inside the programmed window.
// - With both cursors on, bitmap and cross hair combine by OR or XOR.
// - Coordinates are 12 bits; upper nibble of each high byte reads zero.
// - Position registers have no reset value and are always accessible.
// - Software subtracts the 37/52/57 pixel pipeline offset from cursor x.
// - Cursor y codes 0xFC0..0xFFF are negative, allowing off-top placement.
// - Processor RAM accesses win over display fetches.
// - Window origin registers are 12-bit upper-left corner, high nibble zero.
// - Pointer bits 8..0 step after RAM/control access; wraps to zero as defined; a control read at 0x1FF keeps bits 15..9.
// - Command bits 6..4 enables and OR select; 3..2 mux; 1..0 thickness.
// - Write data is taken on the rising edge of chip select.
// - Lane A is left-most; unused lanes stay zero.
package cursor_pkg;
  // ------------------------------------------------------------
  // Processor access codes and control register indices
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_PTR_LO = 2'h0;
  localparam logic [1:0] SEL_PTR_HI = 2'h1;
  localparam logic [1:0] SEL_RAM = 2'h2;
  localparam logic [1:0] SEL_CTRL = 2'h3;
  localparam logic [3:0] REG_COMMAND = 4'h0;
  localparam logic [3:0] REG_CURSOR_X_LOW = 4'h1;
  localparam logic [3:0] REG_CURSOR_Y_LOW = 4'h3;
  localparam logic [3:0] REG_WINDOW_ORIGIN_X_LOW = 4'h5;
  localparam logic [3:0] REG_WINDOW_ORIGIN_Y_LOW = 4'h7;
  localparam logic [3:0] REG_WINDOW_SPAN_X_LOW = 4'h9;
  localparam logic [3:0] REG_WINDOW_SPAN_Y_LOW = 4'hB;
  localparam logic [3:0] REG_LAST = 4'hC;
  localparam logic [8:0] RAM_LAST = 9'h1FF;
  localparam logic [7:0] HIGH_BYTE_MASK = 8'h0F;
  // ------------------------------------------------------------
  // Command register fields
  // ------------------------------------------------------------
  localparam int CMD_BITMAP_EN = 6;
  localparam int CMD_CROSS_EN = 5;
  localparam int CMD_OR_SEL = 4;
  localparam int CMD_MUX_LSB = 2;
  localparam int CMD_THICK_LSB = 0;
  localparam logic [7:0] CMD_RESET = 8'h00;
  typedef enum logic [1:0] {MUX_1 = 2'h0, MUX_4 = 2'h1, MUX_5 = 2'h2} mux_e;
  // ------------------------------------------------------------
  // Display geometry and timing
  // ------------------------------------------------------------
  localparam int LANES = 5;
  localparam logic signed [14:0] BITMAP_CENTRE = 15'sh001F;
  localparam logic signed [14:0] BITMAP_SIZE = 15'sh0040;
  localparam logic [11:0] Y_NEG_START = 12'hFC0;
  localparam logic [14:0] WIN_EXTRA_X1 = 15'h0002;
  localparam logic [14:0] WIN_EXTRA_X4 = 15'h0008;
  localparam logic [14:0] WIN_EXTRA_X5 = 15'h000A;
  localparam logic [14:0] WIN_EXTRA_Y = 15'h0002;
  localparam int VS_GAP_CYCLES = 2;
  typedef struct packed {
    logic rw;
    logic [1:0] sel;
    logic [7:0] data;
  } host_req_s;
endpackage

// ===== logic/cursor_gen.sv
// Hardware cursor generator: processor port, cursor RAM, overlay pixel engine
`timescale 1ns/1ns
module cursor_gen #(
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Processor port
  input wire logic cs_n_in,
  input wire logic rw_in,
  input wire logic select_line_zero_in,
  input wire logic select_line_one_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  // Video timing
  input wire logic hsync_n_in,
  input wire logic vsync_n_in,
  // Overlay stream to palette converter
  input wire logic overlay_ready_in,
  output logic overlay_valid_out,
  output logic [cursor_pkg::LANES-1:0] overlay_bits_out
);
  import cursor_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] cursor_ram [0:511];
  logic [7:0] ctl_r [1:12];
  logic [7:0] command_r;
  logic [15:0] access_pointer_r;
  host_req_s req_r;
  logic cs_q_r;
  logic hs_q_r;
  logic vs_q_r;
  logic vs_pend_r;
  logic [1:0] vs_age_r;
  logic [12:0] x_r;
  logic [12:0] y_r;

  // ------------------------------------------------------------
  // Processor access decode
  // ------------------------------------------------------------
  wire [1:0] sel_now = {select_line_one_in, select_line_zero_in};
  wire access_end = !cs_q_r && cs_n_in;
  wire do_write = access_end && !req_r.rw;
  wire [3:0] reg_idx = access_pointer_r[3:0];
  wire reg_valid = (reg_idx != REG_COMMAND) && (reg_idx <= REG_LAST);
  wire [8:0] ptr_low = access_pointer_r[8:0];
  wire [8:0] ptr_step = ptr_low + 9'h001;
  wire ptr_wrap = (ptr_low == RAM_LAST) && (req_r.sel == SEL_RAM || !req_r.rw);
  wire [15:0] ptr_next = ptr_wrap ? 16'h0000 : {access_pointer_r[15:9], ptr_step};
  wire [7:0] ctl_rd = (reg_idx == REG_COMMAND) ? command_r :
                      reg_valid ? ctl_r[reg_idx] : 8'h00;
  wire [7:0] rd_mux = (sel_now == SEL_PTR_LO) ? access_pointer_r[7:0] :
                      (sel_now == SEL_PTR_HI) ? access_pointer_r[15:8] :
                      (sel_now == SEL_RAM) ? cursor_ram[ptr_low] : ctl_rd;
  wire [7:0] wr_byte = reg_idx[0] ? req_r.data : (req_r.data & HIGH_BYTE_MASK);

  // Request held while chip select is low; committed on its rising edge
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_r <= '0;
      cs_q_r <= 1'b1;
    end else begin
      cs_q_r <= cs_n_in;
      if (!cs_n_in) begin
        req_r <= '{rw: rw_in, sel: sel_now, data: data_in};
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      access_pointer_r <= 16'h0000;
    end else if (do_write && req_r.sel == SEL_PTR_LO) begin
      access_pointer_r[7:0] <= req_r.data;
    end else if (do_write && req_r.sel == SEL_PTR_HI) begin
      access_pointer_r[15:8] <= req_r.data;
    end else if (access_end && req_r.sel[1]) begin
      access_pointer_r <= ptr_next;
    end
  end

  // Command reset only so the overlay is quiet after power-up
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      command_r <= CMD_RESET;
    end else if (do_write && req_r.sel == SEL_CTRL && reg_idx == REG_COMMAND) begin
      command_r <= req_r.data;
    end
  end

  // Position registers keep no reset value
  always_ff @(posedge clock_in) begin
    if (do_write && req_r.sel == SEL_CTRL && reg_valid) begin
      ctl_r[reg_idx] <= wr_byte;
    end
  end

  // Processor writes go in unconditionally; display reads never block them
  always_ff @(posedge clock_in) begin
    if (do_write && req_r.sel == SEL_RAM) begin
      cursor_ram[ptr_low] <= req_r.data;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_out <= 8'h00;
      data_oe_out <= 1'b0;
    end else begin
      data_oe_out <= !cs_n_in && rw_in;
      if (!cs_n_in && rw_in) begin
        data_out <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------
  // Raster counters
  // ------------------------------------------------------------
  wire hs_fall = hs_q_r && !hsync_n_in;
  wire vs_fall = vs_q_r && !vsync_n_in;
  wire vs_armed = vs_pend_r && (vs_age_r >= 2'(VS_GAP_CYCLES));
  wire push;
  wire [2:0] lanes_on = (command_r[CMD_MUX_LSB +: 2] == MUX_5) ? 3'h5 :
                        (command_r[CMD_MUX_LSB +: 2] == MUX_4) ? 3'h4 : 3'h1;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hs_q_r <= 1'b1;
      vs_q_r <= 1'b1;
      vs_pend_r <= 1'b0;
      vs_age_r <= 2'h0;
    end else begin
      hs_q_r <= hsync_n_in;
      vs_q_r <= vsync_n_in;
      if (vs_fall) begin
        vs_pend_r <= 1'b1;
        vs_age_r <= 2'h1;
      end else if (hs_fall && vs_armed) begin
        vs_pend_r <= 1'b0;
      end else if (vs_pend_r && vs_age_r != 2'h3) begin
        vs_age_r <= vs_age_r + 2'h1;
      end
    end
  end

  // Counters saturate so a long line never wraps into a cursor
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      x_r <= 13'h1FFF;
      y_r <= 13'h1FFF;
    end else begin
      if (hs_fall) begin
        x_r <= 13'h0000;
      end else if (push && x_r < 13'h1FF0) begin
        x_r <= x_r + 13'(lanes_on);
      end
      if (hs_fall && vs_armed) begin
        y_r <= 13'h0000;
      end else if (hs_fall && y_r != 13'h1FFF) begin
        y_r <= y_r + 13'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Pixel engine
  // ------------------------------------------------------------
  wire [11:0] cx = {ctl_r[REG_CURSOR_X_LOW + 4'h1][3:0], ctl_r[REG_CURSOR_X_LOW]};
  wire [11:0] cy = {ctl_r[REG_CURSOR_Y_LOW + 4'h1][3:0], ctl_r[REG_CURSOR_Y_LOW]};
  wire [11:0] wx = {ctl_r[REG_WINDOW_ORIGIN_X_LOW + 4'h1][3:0], ctl_r[REG_WINDOW_ORIGIN_X_LOW]};
  wire [11:0] wy = {ctl_r[REG_WINDOW_ORIGIN_Y_LOW + 4'h1][3:0], ctl_r[REG_WINDOW_ORIGIN_Y_LOW]};
  wire [11:0] ww = {ctl_r[REG_WINDOW_SPAN_X_LOW + 4'h1][3:0], ctl_r[REG_WINDOW_SPAN_X_LOW]};
  wire [11:0] wh = {ctl_r[REG_WINDOW_SPAN_Y_LOW + 4'h1][3:0], ctl_r[REG_WINDOW_SPAN_Y_LOW]};
  wire signed [14:0] cx_s = $signed({3'b000, cx});
  wire signed [14:0] cy_s = (cy >= Y_NEG_START) ? $signed({3'b111, cy}) :
                            $signed({3'b000, cy});
  wire signed [14:0] py_s = $signed({2'b00, y_r});
  wire signed [14:0] dy = py_s - cy_s + BITMAP_CENTRE;
  wire signed [14:0] ay = py_s - cy_s;
  wire signed [14:0] wdy = py_s - $signed({3'b000, wy});
  wire signed [14:0] half = $signed({13'h0000, command_r[CMD_THICK_LSB +: 2]});
  wire [14:0] win_w = {3'b000, ww} + ((lanes_on == 3'h5) ? WIN_EXTRA_X5 :
                      (lanes_on == 3'h4) ? WIN_EXTRA_X4 : WIN_EXTRA_X1);
  wire [14:0] win_h = {3'b000, wh} + WIN_EXTRA_Y;
  wire row_in = (dy >= 0) && (dy < BITMAP_SIZE);
  wire row_cross = (ay >= -half) && (ay <= half);
  wire row_win = (wdy >= 0) && (wdy < $signed(win_h));
  wire bm_en = command_r[CMD_BITMAP_EN];
  wire ch_en = command_r[CMD_CROSS_EN];
  logic [LANES-1:0] gen_bits;

  // Lane 0 (A) is the left-most pixel of the group
  for (genvar k = 0; k < LANES; k++) begin : g_lane
    wire signed [14:0] px = $signed({2'b00, x_r}) + 15'(k);
    wire signed [14:0] dx = px - cx_s + BITMAP_CENTRE;
    wire signed [14:0] ax = px - cx_s;
    wire signed [14:0] wdx = px - $signed({3'b000, wx});
    wire in_box = row_in && (dx >= 0) && (dx < BITMAP_SIZE);
    wire [7:0] ram_byte = cursor_ram[{dy[5:0], dx[5:3]}];
    wire bm_bit = bm_en && in_box && ram_byte[~dx[2:0]];
    wire in_win = row_win && (wdx >= 0) && (wdx < $signed(win_w));
    wire col_cross = (ax >= -half) && (ax <= half);
    wire ch_bit = ch_en && in_win && (row_cross || col_cross);
    wire both = bm_bit && ch_bit && !command_r[CMD_OR_SEL];
    assign gen_bits[k] = (k < lanes_on) && (bm_bit || ch_bit) && !both;
  end

  // ------------------------------------------------------------
  // Two-entry buffer toward the palette converter
  // ------------------------------------------------------------
  // A stall holds the pixel counter, so the stream resumes without a gap
  logic [LANES-1:0] buf_r [0:DEPTH-1];
  logic [$clog2(DEPTH)-1:0] wr_ptr_r;
  logic [$clog2(DEPTH)-1:0] rd_ptr_r;
  logic [$clog2(DEPTH):0] count_r;
  wire buf_ready = count_r < ($clog2(DEPTH)+1)'(DEPTH);
  wire pop = (count_r != '0) && (!overlay_valid_out || overlay_ready_in);
  assign push = buf_ready;
  wire [$clog2(DEPTH):0] count_nxt = count_r + ($clog2(DEPTH)+1)'(push) -
                                     ($clog2(DEPTH)+1)'(pop);

  always_ff @(posedge clock_in) begin
    if (push) begin
      buf_r[wr_ptr_r] <= gen_bits;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      overlay_valid_out <= 1'b0;
      overlay_bits_out <= '0;
    end else begin
      count_r <= count_nxt;
      if (push) begin
        wr_ptr_r <= ($clog2(DEPTH))'((wr_ptr_r + 1'b1) % DEPTH);
      end
      if (pop) begin
        rd_ptr_r <= ($clog2(DEPTH))'((rd_ptr_r + 1'b1) % DEPTH);
        overlay_bits_out <= buf_r[rd_ptr_r];
        overlay_valid_out <= 1'b1;
      end else if (overlay_ready_in) begin
        overlay_valid_out <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  lane_mask_a: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    command_r[CMD_MUX_LSB +: 2] == MUX_1 |-> gen_bits[LANES-1:1] == '0)
    else $error("unused overlay lanes active in single-pixel mode");
  ptr_step_a: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    access_end && req_r.sel == SEL_RAM && ptr_low != RAM_LAST
    |=> access_pointer_r[8:0] == $past(ptr_low) + 9'h001)
    else $error("pointer did not step after RAM access");
  ptr_wrap_a: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    access_end && req_r.sel == SEL_RAM && ptr_low == RAM_LAST
    |=> access_pointer_r == 16'h0000)
    else $error("pointer did not wrap after last RAM byte");
  ptr_hold_a: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    access_end && req_r.rw && !req_r.sel[1] |=> $stable(access_pointer_r))
    else $error("pointer changed on address byte read");
  ptr_load_a: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    do_write && req_r.sel == SEL_PTR_LO |=> access_pointer_r[7:0] == $past(req_r.data))
    else $error("pointer low byte not loaded at chip select release");
  high_zero_a: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    !cs_n_in && rw_in && sel_now == SEL_CTRL && reg_valid && !reg_idx[0]
    |=> data_out[7:4] == 4'h0)
    else $error("high coordinate byte upper nibble not zero");
  line_start_a: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    hs_fall |=> x_r == 13'h0000 ##1 x_r <= 13'h0005)
    else $error("pixel count not restarted after horizontal sync");
  quiet_off_a: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    !bm_en && !ch_en |-> gen_bits == '0)
    else $error("overlay bits set with both cursors disabled");
  stall_hold_a: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    !buf_ready && !hs_fall |=> x_r == $past(x_r))
    else $error("pixel count advanced while buffer full");
endmodule

// ===== verification/cursor_gen_bench.sv
// Self-checking bench for the hardware cursor generator
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, got, exp); end end
module cursor_gen_bench;
  import cursor_pkg::*;
  logic clock_in, nrst_in, cs_n, rw, sel0, sel1, hsync_n, vsync_n, ready, valid, oe, stall_en;
  logic [7:0] data_in, data_out, cmd, q;
  logic [LANES-1:0] bits, exp_w;
  logic [7:0] ram [512];
  int error_cnt, n_compared, cyc, hold_err, cx, cy, wx, wy, ww, wh, m, lanes;
  cursor_gen u_cursor_gen (.clock_in(clock_in), .nrst_in(nrst_in), .cs_n_in(cs_n), .rw_in(rw),
    .select_line_zero_in(sel0), .select_line_one_in(sel1), .data_in(data_in),
    .data_out(data_out), .data_oe_out(oe), .hsync_n_in(hsync_n), .vsync_n_in(vsync_n),
    .overlay_ready_in(ready), .overlay_valid_out(valid), .overlay_bits_out(bits));
  overlay_sink u_overlay_sink (.clock_in(clock_in), .nrst_in(nrst_in), .overlay_valid_in(valid),
    .overlay_bits_in(bits), .stall_en_in(stall_en), .overlay_ready_out(ready),
    .hold_err_out(hold_err));
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  // --------------------------------------------------------------
  // Verdict, host accesses and expected pixels
  // --------------------------------------------------------------
  task automatic results;
    error_cnt += hold_err;
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  // One access: strobe low for one cycle, then high for at least one
  task automatic acc(input logic rd, input logic [1:0] sel, input logic [7:0] d);
    @(negedge clock_in);
    cs_n = 1'b0;
    rw = rd;
    {sel1, sel0} = sel;
    data_in = d;
    @(negedge clock_in);
    q = data_out;
    if (rd) `CHK(oe, 1'b1)
    cs_n = 1'b1;
  endtask
  task automatic rd_chk(input logic [1:0] sel, input logic [7:0] e);
    acc(1'b1, sel, 8'h00);
    `CHK(q, e)
  endtask
  function automatic logic [7:0] hb(int v);
    return {4'($urandom), 4'(v >> 8)};
  endfunction
  function automatic logic pix(int x, int y);
    int c, r, e, th;
    logic bm, ch;
    c = x - cx + 31;
    r = y - cy + 31;
    th = int'(cmd[1:0]);
    e = (m == 0) ? 2 : (m == 1) ? 8 : 10;
    bm = cmd[6] && c >= 0 && c < 64 && r >= 0 && r < 64 && ram[r * 8 + c / 8][7 - c % 8];
    ch = cmd[5] && ((x - cx <= th && cx - x <= th) || (y - cy <= th && cy - y <= th));
    ch = ch && x >= wx && x - wx < ww + e && y >= wy && y - wy < wh + 2;
    return cmd[4] ? (bm | ch) : (bm ^ ch);
  endfunction
  // Program one mode, read the registers back, then capture four lines
  task automatic show(input int mode, input int cyv);
    logic [7:0] r [13];
    logic [7:0] lo, hi;
    m = mode;
    lanes = (mode == 0) ? 1 : (mode == 1) ? 4 : 5;
    cx = 40;
    cy = cyv;
    wx = 20;
    wy = 0;
    ww = 30;
    wh = 'hFFF;
    // Off-top placement clears the cross hair enable (command bit 5), so no cross hair
    cmd = {1'b0, 1'b1, 1'(cy >= 0), 1'($urandom), 2'(mode), 2'($urandom)};
    r = '{cmd, 8'(cx), hb(cx), 8'(cy), hb(cy), 8'(wx), hb(wx), 8'(wy), hb(wy), 8'(ww), hb(ww),
      8'(wh), hb(wh)};
    hi = 8'($urandom);
    lo = {4'($urandom), 4'h0};
    acc(1'b0, SEL_PTR_LO, lo);
    acc(1'b0, SEL_PTR_HI, hi);
    foreach (r[i]) acc(1'b0, SEL_CTRL, r[i]);
    rd_chk(SEL_PTR_LO, lo + 8'h0D);
    rd_chk(SEL_PTR_HI, hi);
    rd_chk(SEL_CTRL, 8'h00);
    acc(1'b0, SEL_PTR_LO, lo);
    foreach (r[i]) begin
      rd_chk(SEL_CTRL, (i % 2 == 0 && i > 0) ? r[i] & HIGH_BYTE_MASK : r[i]);
    end
    @(negedge clock_in);
    vsync_n = 1'b0;
    repeat (3) @(negedge clock_in);
    vsync_n = 1'b1;
    for (int y = 0; y < 4; y++) begin
      stall_en = 1'b1;
      repeat (10) @(negedge clock_in);
      stall_en = 1'b0;
      repeat (4) @(negedge clock_in);
      hsync_n = 1'b0;
      @(negedge clock_in);
      hsync_n = 1'b1;
      repeat (2) @(negedge clock_in);
      for (int j = 0; j < 40; j++) begin
        for (int k = 0; k < LANES; k++) exp_w[k] = k < lanes && pix(j * lanes + k, y);
        `CHK(bits, exp_w)
        `CHK(valid, 1'b1)
        @(negedge clock_in);
      end
    end
  endtask
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    void'($urandom(94));
    {cs_n, hsync_n, vsync_n} = 3'h7;
    {rw, sel0, sel1, stall_en, nrst_in} = 5'h00;
    data_in = 8'h00;
    error_cnt = 0;
    n_compared = 0;
    cyc = 0;
    repeat (5) @(negedge clock_in);
    `CHK({valid, bits, oe}, 7'h00)
    nrst_in = 1'b1;
    rd_chk(SEL_CTRL, CMD_RESET);
    acc(1'b0, SEL_PTR_LO, 8'h00);
    acc(1'b0, SEL_PTR_HI, 8'h00);
    for (int i = 0; i < 512; i++) begin
      ram[i] = 8'($urandom);
      acc(1'b0, SEL_RAM, ram[i]);
    end
    rd_chk(SEL_PTR_LO, 8'h00);
    rd_chk(SEL_PTR_HI, 8'h00);
    for (int i = 0; i < 512; i++) rd_chk(SEL_RAM, ram[i]);
    acc(1'b0, SEL_PTR_LO, 8'hFF);
    acc(1'b0, SEL_PTR_HI, 8'h01);
    acc(1'b0, SEL_CTRL, 8'($urandom));
    rd_chk(SEL_PTR_LO, 8'h00);
    rd_chk(SEL_PTR_HI, 8'h00);
    acc(1'b0, SEL_PTR_LO, 8'hFF);
    acc(1'b0, SEL_PTR_HI, 8'hFF);
    rd_chk(SEL_CTRL, 8'h00);
    rd_chk(SEL_PTR_LO, 8'h00);
    rd_chk(SEL_PTR_HI, 8'hFE);
    show(0, 1);
    show(1, -1);
    show(2, 2);
    results();
  end
endmodule

// ===== verification/overlay_sink.sv
// Palette-side overlay sink model with random stalls and a hold check
`timescale 1ns/1ns
module overlay_sink (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Overlay stream from the cursor generator
  input wire logic overlay_valid_in,
  input wire logic [cursor_pkg::LANES-1:0] overlay_bits_in,
  input wire logic stall_en_in,
  output logic overlay_ready_out,
  output int hold_err_out
);
  import cursor_pkg::*;
  logic [LANES-1:0] last_r;
  logic stalled_r;
  initial begin
    overlay_ready_out = 1'b1;
    hold_err_out = 0;
    stalled_r = 1'b0;
  end
  // --------------------------------------------------------------
  // Stall only on request, so captured lines keep a fixed timing
  // --------------------------------------------------------------
  always @(negedge clock_in) begin
    overlay_ready_out <= stall_en_in ? 1'($urandom % 2) : 1'b1;
  end
  // A refused word has to stand until the sink takes it
  always @(posedge clock_in) begin
    if (nrst_in && stalled_r && overlay_valid_in && overlay_bits_in !== last_r) begin
      hold_err_out <= hold_err_out + 1;
    end
    stalled_r <= nrst_in && overlay_valid_in && !overlay_ready_out;
    last_r <= overlay_bits_in;
  end
endmodule
